// ---- hdl/dlt_timer_top.sv ----
// Two legacy counter/timers with shared prescaler and clock select register.
`timescale 1ns/1ns
module dlt_timer_top
   import dlt_pkg::*;
(
   input  wire logic       mclk_i,               // System clock, 125 MHz.
   input  wire logic       reset_n_i,            // Asynchronous reset, low.
   input  wire logic [7:0] sfr_addr_i,           // Register address.
   input  wire logic       sfr_wr_i,             // Write strobe.
   input  wire logic [7:0] sfr_wdata_i,          // Write data.
   output logic      [7:0] sfr_rdata_o,          // Read data, one cycle later.
   input  wire logic       tmr_a_count_pin_i,    // Timer A event pin.
   input  wire logic       tmr_b_count_pin_i,    // Timer B event pin.
   input  wire logic       ext_irq_a_input_i,    // First interrupt pin.
   input  wire logic       ext_irq_b_input_i,    // Second interrupt pin.
   input  wire logic       ext_irq_a_polarity_i, // 1: first pin active high.
   input  wire logic       ext_irq_b_polarity_i, // 1: second pin active high.
   input  wire logic       ext_osc_clk_i,        // External oscillator pin.
   input  wire logic       tmr_a_irq_enable_i,   // Timer A interrupt enable.
   input  wire logic       tmr_b_irq_enable_i,   // Timer B interrupt enable.
   input  wire logic       tmr_a_irq_ack_i,      // CPU vectors to timer A.
   input  wire logic       tmr_b_irq_ack_i,      // CPU vectors to timer B.
   input  wire logic       tmr_c_split_i,        // Timer C in split mode.
   input  wire logic       tmr_d_split_i,        // Timer D in split mode.
   output logic            tmr_a_irq_o,          // Timer A interrupt request.
   output logic            tmr_b_irq_o,          // Timer B interrupt request.
   output logic            tmr_b_overflow_o,     // Baud and converter pulse.
   output logic            tmr_c_low_sysclk_o,   // Timer C low on sysclk.
   output logic            tmr_c_high_sysclk_o,  // Timer C high on sysclk.
   output logic            tmr_d_low_sysclk_o,   // Timer D low on sysclk.
   output logic            tmr_d_high_sysclk_o   // Timer D high on sysclk.
);

   logic [7:0]  timer_clock_select;
   logic [7:0]  timer_mode_reg;
   logic [7:0]  tmr_a_low_byte;
   logic [7:0]  tmr_a_high_byte;
   logic [7:0]  tmr_b_low_byte;
   logic [7:0]  tmr_b_high_byte;
   logic        tmr_a_run;
   logic        tmr_b_run;
   logic        tmr_a_overflow_flag;
   logic        tmr_b_overflow_flag;
   logic [3:0]  pin_meta;
   logic [3:0]  pin_sync;
   logic [1:0]  pin_prev;
   logic        presc_tick;
   logic [16:0] step_a;
   logic [16:0] step_b;
   logic [7:0]  next_rdata;
   dlt_mode_t   mode_a;
   dlt_mode_t   mode_b;

   // One count step: {overflow, high byte, low byte}.
   function automatic logic [16:0] f_step(input dlt_mode_t mode,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h0_0001;
      c8  = {1'b0, lo} + 9'h001;
      case (mode)
         DLT_M13:       f_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         DLT_M16:       f_step = c16;
         DLT_M8_RELOAD: f_step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
         default:       f_step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction : f_step

   function automatic logic f_wr(input logic [7:0] addr);
      f_wr = sfr_wr_i && (sfr_addr_i == addr);
   endfunction : f_wr

   assign mode_a = dlt_mode_t'(timer_mode_reg[MD_A_HI:MD_A_LO]);
   assign mode_b = dlt_mode_t'(timer_mode_reg[MD_B_HI:MD_B_LO]);

   // Pins cross into mclk; the first stage is read only by the second.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_prev <= 2'h0;
      end else begin
         pin_meta <= {ext_irq_b_input_i, ext_irq_a_input_i,
                      tmr_b_count_pin_i, tmr_a_count_pin_i};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync[1:0];
      end
   end

   dlt_prescaler u_prescaler (
      .mclk_i           (mclk_i),
      .reset_n_i        (reset_n_i),
      .divider_select_i (timer_clock_select[CS_DIV_HI:CS_DIV_LO]),
      .ext_osc_clk_i    (ext_osc_clk_i),
      .tick_o           (presc_tick)
   );

   // Counting conditions.
   logic a_split;
   logic fall_a;
   logic fall_b;
   logic gate_a_ok;
   logic gate_b_ok;
   logic src_a;
   logic src_b;
   logic run_a;
   logic run_b;
   logic inc_a;
   logic inc_b;
   logic inc_ah;
   logic ovf_a;
   logic ovf_b;
   logic ovf_ah;
   logic set_flag_b;

   assign a_split   = (mode_a == DLT_MSPLIT);
   assign fall_a    = pin_prev[0] & ~pin_sync[0];
   assign fall_b    = pin_prev[1] & ~pin_sync[1];
   assign gate_a_ok = ~timer_mode_reg[MD_A_GATE] |
                      (pin_sync[2] == ext_irq_a_polarity_i);
   assign gate_b_ok = ~timer_mode_reg[MD_B_GATE] |
                      (pin_sync[3] == ext_irq_b_polarity_i);
   assign src_a     = timer_mode_reg[MD_A_CNT] ? fall_a :
                      (timer_clock_select[CS_A] | presc_tick);
   // Split mode keeps timer B off its pin.
   assign src_b     = (timer_mode_reg[MD_B_CNT] && !a_split) ? fall_b :
                      (timer_clock_select[CS_B] | presc_tick);
   assign run_a     = tmr_a_run & gate_a_ok;
   assign run_b     = a_split ? 1'b1 : (tmr_b_run & gate_b_ok);
   assign inc_a     = run_a & src_a;
   assign inc_b     = run_b & src_b & (mode_b != DLT_MSPLIT);
   assign inc_ah    = a_split & tmr_b_run &
                      (timer_clock_select[CS_A] | presc_tick);
   assign step_a    = f_step(mode_a, tmr_a_high_byte, tmr_a_low_byte);
   assign step_b    = f_step(mode_b, tmr_b_high_byte, tmr_b_low_byte);
   assign ovf_a     = inc_a & step_a[16];
   assign ovf_b     = inc_b & step_b[16];
   assign ovf_ah    = inc_ah & (tmr_a_high_byte == 8'hff);
   assign set_flag_b = a_split ? ovf_ah : ovf_b;

   // Timer A count bytes; a software write wins over a count.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_a_low_byte <= RST_COUNT;
      end else if (f_wr(ADDR_A_LOW)) begin
         tmr_a_low_byte <= sfr_wdata_i;
      end else if (inc_a) begin
         tmr_a_low_byte <= step_a[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_a_high_byte <= RST_COUNT;
      end else if (f_wr(ADDR_A_HIGH)) begin
         tmr_a_high_byte <= sfr_wdata_i;
      end else if (a_split) begin
         if (inc_ah) begin
            tmr_a_high_byte <= tmr_a_high_byte + 8'h01;
         end
      end else if (inc_a) begin
         tmr_a_high_byte <= step_a[15:8];
      end
   end

   // Timer B count bytes.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_b_low_byte  <= RST_COUNT;
         tmr_b_high_byte <= RST_COUNT;
      end else begin
         if (f_wr(ADDR_B_LOW)) begin
            tmr_b_low_byte <= sfr_wdata_i;
         end else if (inc_b) begin
            tmr_b_low_byte <= step_b[7:0];
         end
         if (f_wr(ADDR_B_HIGH)) begin
            tmr_b_high_byte <= sfr_wdata_i;
         end else if (inc_b) begin
            tmr_b_high_byte <= step_b[15:8];
         end
      end
   end

   // Configuration registers. Run bits only gate; they never touch counts.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer_clock_select <= RST_CLK_SEL;
         timer_mode_reg     <= RST_MODE;
         tmr_a_run          <= RST_BIT;
         tmr_b_run          <= RST_BIT;
      end else begin
         if (f_wr(ADDR_CLK_SEL)) begin
            timer_clock_select <= sfr_wdata_i;
         end
         if (f_wr(ADDR_MODE)) begin
            timer_mode_reg <= sfr_wdata_i;
         end
         if (f_wr(ADDR_RUN_FLAG)) begin
            tmr_a_run <= sfr_wdata_i[RF_A_RUN];
            tmr_b_run <= sfr_wdata_i[RF_B_RUN];
         end
      end
   end

   // Flags: a hardware set beats both the vector clear and a software write.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_a_overflow_flag <= RST_BIT;
      end else if (ovf_a) begin
         tmr_a_overflow_flag <= 1'b1;
      end else if (tmr_a_irq_ack_i) begin
         tmr_a_overflow_flag <= 1'b0;
      end else if (f_wr(ADDR_RUN_FLAG)) begin
         tmr_a_overflow_flag <= sfr_wdata_i[RF_A_FLAG];
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_b_overflow_flag <= RST_BIT;
      end else if (set_flag_b) begin
         tmr_b_overflow_flag <= 1'b1;
      end else if (tmr_b_irq_ack_i) begin
         tmr_b_overflow_flag <= 1'b0;
      end else if (f_wr(ADDR_RUN_FLAG)) begin
         tmr_b_overflow_flag <= sfr_wdata_i[RF_B_FLAG];
      end
   end

   // Outputs, all registered.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tmr_a_irq_o         <= 1'b0;
         tmr_b_irq_o         <= 1'b0;
         tmr_b_overflow_o    <= 1'b0;
         tmr_c_low_sysclk_o  <= 1'b0;
         tmr_c_high_sysclk_o <= 1'b0;
         tmr_d_low_sysclk_o  <= 1'b0;
         tmr_d_high_sysclk_o <= 1'b0;
      end else begin
         tmr_a_irq_o <= tmr_a_overflow_flag & tmr_a_irq_enable_i;
         tmr_b_irq_o <= tmr_b_overflow_flag & tmr_b_irq_enable_i;
         tmr_b_overflow_o    <= ovf_b;
         tmr_c_low_sysclk_o  <= timer_clock_select[CS_C_LOW];
         tmr_c_high_sysclk_o <= timer_clock_select[CS_C_HIGH] &
                                tmr_c_split_i;
         tmr_d_low_sysclk_o  <= timer_clock_select[CS_D_LOW];
         tmr_d_high_sysclk_o <= timer_clock_select[CS_D_HIGH] &
                                tmr_d_split_i;
      end
   end

   // Read data follows the address with one cycle of latency.
   always_comb begin
      case (sfr_addr_i)
         ADDR_RUN_FLAG: next_rdata = {tmr_b_overflow_flag, tmr_b_run,
                                      tmr_a_overflow_flag, tmr_a_run, 4'h0};
         ADDR_MODE:     next_rdata = timer_mode_reg;
         ADDR_A_LOW:    next_rdata = tmr_a_low_byte;
         ADDR_B_LOW:    next_rdata = tmr_b_low_byte;
         ADDR_A_HIGH:   next_rdata = tmr_a_high_byte;
         ADDR_B_HIGH:   next_rdata = tmr_b_high_byte;
         ADDR_CLK_SEL:  next_rdata = timer_clock_select;
         default:       next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sfr_rdata_o <= 8'h00;
      end else begin
         sfr_rdata_o <= next_rdata;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   logic no_wr;
   assign no_wr = !sfr_wr_i;

   sequence s_a_pin_fall;
      timer_mode_reg[MD_A_CNT] && run_a && mode_a == DLT_M16 &&
      pin_prev[0] && !pin_sync[0] && no_wr;
   endsequence

   a_gate_hold: assert property (
      (!run_a && no_wr) |=> $stable(tmr_a_low_byte))
      else $error("timer A low byte moved while gated off");

   a_pin_count: assert property (
      s_a_pin_fall |=> tmr_a_low_byte == $past(tmr_a_low_byte) + 8'h01)
      else $error("pin falling edge did not count");

   a_m0_wrap: assert property (
      (mode_a == DLT_M13 && inc_a && tmr_a_high_byte == 8'hff &&
       tmr_a_low_byte[4:0] == 5'h1f && no_wr)
      |=> tmr_a_overflow_flag && tmr_a_high_byte == 8'h00 &&
          tmr_a_low_byte[4:0] == 5'h00)
      else $error("13-bit wrap did not flag");

   a_m1_wrap: assert property (
      (mode_a == DLT_M16 && inc_a && tmr_a_high_byte == 8'hff &&
       tmr_a_low_byte == 8'hff && no_wr)
      |=> tmr_a_high_byte == 8'h00 && tmr_a_low_byte == 8'h00)
      else $error("16-bit wrap wrong");

   a_m2_reload: assert property (
      (!a_split && mode_b == DLT_M8_RELOAD && inc_b &&
       tmr_b_low_byte == 8'hff && no_wr)
      |=> tmr_b_low_byte == $past(tmr_b_high_byte) &&
          $stable(tmr_b_high_byte) && tmr_b_overflow_flag &&
          tmr_b_overflow_o)
      else $error("auto-reload did not reload or flag");

   a_b_mode3_hold: assert property (
      (mode_b == DLT_MSPLIT && no_wr) |=> $stable(tmr_b_low_byte) &&
                                         $stable(tmr_b_high_byte))
      else $error("timer B moved in mode 3");

   a_split_no_flag: assert property (
      (a_split && !ovf_ah && !tmr_b_overflow_flag && no_wr)
      |=> !tmr_b_overflow_flag)
      else $error("timer B flag set while A is split");

   a_ack_clear: assert property (
      (tmr_a_irq_ack_i && !ovf_a && no_wr) |=> !tmr_a_overflow_flag)
      else $error("vector did not clear timer A flag");

   a_irq_enable: assert property (
      (tmr_a_overflow_flag && tmr_a_irq_enable_i) ##1 !tmr_a_irq_enable_i
      |-> tmr_a_irq_o ##1 !tmr_a_irq_o)
      else $error("timer A interrupt ignores its enable");

endmodule : dlt_timer_top

// ---- common/dlt_pkg.sv ----
// Register map, field positions, reset values and divider counts.
package dlt_pkg;

   // Register addresses on the special-function-register bus.
   localparam logic [7:0] ADDR_RUN_FLAG  = 8'h88;
   localparam logic [7:0] ADDR_MODE      = 8'h89;
   localparam logic [7:0] ADDR_A_LOW     = 8'h8a;
   localparam logic [7:0] ADDR_B_LOW     = 8'h8b;
   localparam logic [7:0] ADDR_A_HIGH    = 8'h8c;
   localparam logic [7:0] ADDR_B_HIGH    = 8'h8d;
   localparam logic [7:0] ADDR_CLK_SEL   = 8'h8e;

   // Reset values.
   localparam logic [7:0] RST_CLK_SEL    = 8'h00;
   localparam logic [7:0] RST_MODE       = 8'h00;
   localparam logic [7:0] RST_COUNT      = 8'h00;
   localparam logic       RST_BIT        = 1'b0;

   // Field positions in timer_clock_select.
   localparam int CS_D_HIGH = 7;
   localparam int CS_D_LOW  = 6;
   localparam int CS_C_HIGH = 5;
   localparam int CS_C_LOW  = 4;
   localparam int CS_B      = 3;
   localparam int CS_A      = 2;
   localparam int CS_DIV_HI = 1;
   localparam int CS_DIV_LO = 0;

   // Field positions in timer_run_flag_reg.
   localparam int RF_B_FLAG = 7;
   localparam int RF_B_RUN  = 6;
   localparam int RF_A_FLAG = 5;
   localparam int RF_A_RUN  = 4;

   // Field positions in timer_mode_reg.
   localparam int MD_B_GATE = 7;
   localparam int MD_B_CNT  = 6;
   localparam int MD_B_HI   = 5;
   localparam int MD_B_LO   = 4;
   localparam int MD_A_GATE = 3;
   localparam int MD_A_CNT  = 2;
   localparam int MD_A_HI   = 1;
   localparam int MD_A_LO   = 0;

   // Divider select codes and the matching division ratios.
   localparam logic [1:0] DIVSEL_SYS12  = 2'h0;
   localparam logic [1:0] DIVSEL_SYS4   = 2'h1;
   localparam logic [1:0] DIVSEL_SYS48  = 2'h2;
   localparam logic [1:0] DIVSEL_EXT8   = 2'h3;
   localparam logic [5:0] DIV_SYS12     = 6'h0c;
   localparam logic [5:0] DIV_SYS4      = 6'h04;
   localparam logic [5:0] DIV_SYS48     = 6'h30;
   localparam logic [5:0] DIV_EXT8      = 6'h08;

   typedef enum logic [1:0] {
      DLT_M13,
      DLT_M16,
      DLT_M8_RELOAD,
      DLT_MSPLIT
   } dlt_mode_t;

endpackage : dlt_pkg

// ---- hdl/dlt_prescaler.sv ----
// Shared prescaler that makes the timer tick from the system or oscillator.
`timescale 1ns/1ns
module dlt_prescaler
   import dlt_pkg::*;
#(
   parameter int CW = 6
) (
   input  wire logic       mclk_i,            // System clock.
   input  wire logic       reset_n_i,         // Asynchronous reset, low.
   input  wire logic [1:0] divider_select_i,  // Prescale choice.
   input  wire logic       ext_osc_clk_i,     // External oscillator pin.
   output logic            tick_o             // One-cycle prescaled tick.
);

   logic [1:0]    osc_sync;
   logic          osc_prev;
   logic [CW-1:0] cnt;
   logic [CW-1:0] limit;
   logic          step;

   always_comb begin
      case (divider_select_i)
         DIVSEL_SYS12: limit = CW'(DIV_SYS12);
         DIVSEL_SYS4:  limit = CW'(DIV_SYS4);
         DIVSEL_SYS48: limit = CW'(DIV_SYS48);
         default:      limit = CW'(DIV_EXT8);
      endcase
   end

   // The oscillator is foreign to mclk, so only the second stage is used.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_sync <= 2'h0;
         osc_prev <= 1'b0;
      end else begin
         osc_sync <= {osc_sync[0], ext_osc_clk_i};
         osc_prev <= osc_sync[1];
      end
   end

   assign step = (divider_select_i == DIVSEL_EXT8) ?
                 (osc_sync[1] & ~osc_prev) : 1'b1;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt    <= '0;
         tick_o <= 1'b0;
      end else if (step) begin
         if (cnt >= limit - CW'(1)) begin
            cnt    <= '0;
            tick_o <= 1'b1;
         end else begin
            cnt    <= cnt + CW'(1);
            tick_o <= 1'b0;
         end
      end else begin
         tick_o <= 1'b0;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   a_div4_spacing: assert property (
      (tick_o && divider_select_i == DIVSEL_SYS4 &&
       $past(divider_select_i) == DIVSEL_SYS4)
      |-> ##1 !tick_o ##1 !tick_o ##1 !tick_o)
      else $error("prescaled tick came early in divide by four");

endmodule : dlt_prescaler

// ---- testbench/dlt_pin_model.sv ----
// Behavioural model of the event and gate pins around the timers.
`timescale 1ns/1ns
module dlt_pin_model (
   input  wire logic mclk_i,   // System clock.
   output logic      pin_a_o,  // Timer A event pin.
   output logic      pin_b_o,  // Timer B event pin.
   output logic      gate_a_o, // First gate pin.
   output logic      gate_b_o  // Second gate pin.
);
   initial begin
      pin_a_o = 1'b1;
      pin_b_o = 1'b1;
      gate_a_o = 1'b0;
      gate_b_o = 1'b1;
   end
   // Levels stand three clocks, two more than the sampler needs.
   task automatic pulse(input bit b, input int n);
      repeat (n) begin
         @(negedge mclk_i);
         if (b) pin_b_o = 1'b0; else pin_a_o = 1'b0;
         repeat (3) @(negedge mclk_i);
         if (b) pin_b_o = 1'b1; else pin_a_o = 1'b1;
         repeat (3) @(negedge mclk_i);
      end
   endtask : pulse
   task automatic gate(input logic a, input logic b);
      @(negedge mclk_i);
      gate_a_o = a;
      gate_b_o = b;
   endtask : gate
endmodule : dlt_pin_model

// ---- testbench/dual_legacy_timer_counter_tb.sv ----
// Self-checking bench for the dual legacy timer block.
`timescale 1ns/1ns
module dual_legacy_timer_counter_tb;
   import dlt_pkg::*;
   logic       mclk, rst_n, wr, pa, pb, osc, ea, eb, ka, kb, sc, sd, ok;
   logic [7:0] addr, wd, rd, v;
   logic       pin_a, pin_b, ga, gb, ia, ib, bo, cl, ch, dl, dh;
   int         n_fail, samples_checked;
   dlt_timer_top uut (.mclk_i(mclk), .reset_n_i(rst_n), .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rdata_o(rd),
      .tmr_a_count_pin_i(pin_a), .tmr_b_count_pin_i(pin_b),
      .ext_irq_a_input_i(ga), .ext_irq_b_input_i(gb),
      .ext_irq_a_polarity_i(pa), .ext_irq_b_polarity_i(pb),
      .ext_osc_clk_i(osc), .tmr_a_irq_enable_i(ea),
      .tmr_b_irq_enable_i(eb), .tmr_a_irq_ack_i(ka), .tmr_b_irq_ack_i(kb),
      .tmr_c_split_i(sc), .tmr_d_split_i(sd), .tmr_a_irq_o(ia),
      .tmr_b_irq_o(ib), .tmr_b_overflow_o(bo), .tmr_c_low_sysclk_o(cl),
      .tmr_c_high_sysclk_o(ch), .tmr_d_low_sysclk_o(dl),
      .tmr_d_high_sysclk_o(dh));
   dlt_pin_model pm (.mclk_i(mclk), .pin_a_o(pin_a), .pin_b_o(pin_b),
      .gate_a_o(ga), .gate_b_o(gb));
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
   endtask : wreg
   task automatic rget(input logic [7:0] a);
      @(negedge mclk);
      addr = a;
      @(negedge mclk);
      v = rd;
   endtask : rget
   task automatic rreg(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
      rget(a);
      chk(nm, e, v);
   endtask : rreg
   task automatic wirq(input bit b);
      for (int i = 0; i < 4000; i++) begin
         @(negedge mclk);
         if ((b ? ib : ia) === 1'b1) return;
      end
      chk("irq_wait", 8'h01, 8'h00);
      complete_run();
   endtask : wirq
   task automatic seen_ovf();
      ok = 1'b0;
      repeat (40) begin
         @(negedge mclk);
         if (bo === 1'b1) ok = 1'b1;
      end
   endtask : seen_ovf
   task automatic t_regs();
      logic [7:0] am [7] = '{ADDR_RUN_FLAG, ADDR_MODE, ADDR_A_LOW,
         ADDR_B_LOW, ADDR_A_HIGH, ADDR_B_HIGH, ADDR_CLK_SEL};
      for (int i = 0; i < 7; i++) rreg("reset", am[i], RST_COUNT);
      wreg(ADDR_CLK_SEL, 8'hf0);
      wreg(8'h90, 8'hff);
      rreg("clk_sel", ADDR_CLK_SEL, 8'hf0);
      rreg("unmapped", 8'h90, 8'h00);
      chk("c_d_sel", 8'h0e, {4'h0, cl, ch, dl, dh});
      $display("test regs done");
   endtask : t_regs
   task automatic t_ovf();
      for (int m = 0; m < 2; m++) begin
         wreg(ADDR_MODE, 8'(m));
         wreg(ADDR_CLK_SEL, 8'h04);
         wreg(ADDR_A_HIGH, 8'hff);
         wreg(ADDR_A_LOW, (m == 1) ? 8'hfe : 8'h1e);
         wreg(ADDR_RUN_FLAG, 8'h10);
         wirq(1'b0);
         wreg(ADDR_RUN_FLAG, 8'h20);
         rreg("a_flag", ADDR_RUN_FLAG, 8'h20);
         rreg("a_high", ADDR_A_HIGH, 8'h00);
         ea = 1'b0;
         repeat (2) @(negedge mclk);
         chk("a_irq_off", 8'h00, {7'h0, ia});
         ka = 1'b1;
         @(negedge mclk);
         ka = 1'b0;
         ea = 1'b1;
         rreg("a_ack", ADDR_RUN_FLAG, 8'h00);
      end
      $display("test overflow done");
   endtask : t_ovf
   task automatic t_reload();
      wreg(ADDR_MODE, 8'h22);
      wreg(ADDR_CLK_SEL, 8'h0c);
      wreg(ADDR_B_HIGH, 8'h80);
      wreg(ADDR_B_LOW, 8'hfe);
      wreg(ADDR_A_HIGH, 8'h80);
      wreg(ADDR_A_LOW, 8'hfe);
      wreg(ADDR_RUN_FLAG, 8'h50);
      wirq(1'b0);
      wreg(ADDR_RUN_FLAG, 8'h00);
      rreg("reload_high", ADDR_A_HIGH, 8'h80);
      rreg("reload_b_high", ADDR_B_HIGH, 8'h80);
      rget(ADDR_A_LOW);
      chk("reload_low", 8'h01, 8'(v >= 8'h80 && v < 8'h90));
      $display("test reload done");
   endtask : t_reload
   task automatic t_count();
      wreg(ADDR_MODE, 8'hd5);
      wreg(ADDR_A_LOW, 8'h00);
      wreg(ADDR_B_LOW, 8'h00);
      wreg(ADDR_RUN_FLAG, 8'h50);
      pm.pulse(1'b0, 3);
      pm.pulse(1'b1, 2);
      wreg(ADDR_RUN_FLAG, 8'h00);
      rreg("a_events", ADDR_A_LOW, 8'h03);
      wreg(ADDR_MODE, 8'hdd);
      wreg(ADDR_RUN_FLAG, 8'h50);
      pm.pulse(1'b0, 2);
      pm.gate(1'b1, 1'b0);
      pm.pulse(1'b0, 2);
      pm.pulse(1'b1, 2);
      wreg(ADDR_RUN_FLAG, 8'h00);
      rreg("a_gated", ADDR_A_LOW, 8'h05);
      rreg("b_gated", ADDR_B_LOW, 8'h02);
      $display("test counter done");
   endtask : t_count
   task automatic t_presc();
      logic [7:0] ex [4] = '{8'd40, 8'd120, 8'd10, 8'd12};
      wreg(ADDR_MODE, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wreg(ADDR_A_LOW, 8'h00);
         wreg(ADDR_CLK_SEL, 8'(c));
         wreg(ADDR_RUN_FLAG, 8'h10);
         repeat (478) @(negedge mclk);
         wreg(ADDR_RUN_FLAG, 8'h00);
         rget(ADDR_A_LOW);
         ok = (v + 8'd2 >= ex[c]) && (v <= ex[c] + 8'd2);
         chk("prescale", 8'h01, {7'h0, ok});
      end
      $display("test prescale done");
   endtask : t_presc
   task automatic t_split();
      wreg(ADDR_MODE, 8'h13);
      wreg(ADDR_CLK_SEL, 8'h0c);
      wreg(ADDR_A_LOW, 8'h00);
      wreg(ADDR_B_HIGH, 8'hff);
      wreg(ADDR_B_LOW, 8'hf0);
      wreg(ADDR_A_HIGH, 8'hf0);
      seen_ovf();
      chk("b_ovf_split", 8'h01, {7'h0, ok});
      rreg("b_no_flag", ADDR_RUN_FLAG, 8'h00);
      wreg(ADDR_RUN_FLAG, 8'h40);
      wirq(1'b1);
      rreg("a_low_held", ADDR_A_LOW, 8'h00);
      wreg(ADDR_MODE, 8'h33);
      wreg(ADDR_B_LOW, 8'h12);
      seen_ovf();
      chk("b_stopped", 8'h00, {7'h0, ok});
      rreg("b_held", ADDR_B_LOW, 8'h12);
      $display("test split done");
   endtask : t_split
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      osc = 1'b0;
      forever #20 osc = ~osc;
   end
   initial begin
      {rst_n, wr, ka, kb, sd, pb, addr, wd} = '0;
      {pa, ea, eb, sc} = '1;
      n_fail = 0;
      samples_checked = 0;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      t_regs();
      t_ovf();
      t_reload();
      t_count();
      t_presc();
      t_split();
      complete_run();
   end
endmodule : dual_legacy_timer_counter_tb
